// ==== hdl/ldpc_defs.svh ====
// Constants for the table and converter path control register bank
`ifndef LDPC_DEFS_SVH
`define LDPC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define LDPC_ADDR_CFG        8'h80
`define LDPC_ADDR_T1_INDEX   8'h81
`define LDPC_ADDR_T2_INDEX   8'h82
`define LDPC_ADDR_C1_CODE    8'h83
`define LDPC_ADDR_C2_CODE    8'h84
`define LDPC_ADDR_PATH_SEL   8'h85
`define LDPC_NUM_CTRL        6
`define LDPC_LAST_IDX        3'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LDPC_GEN_TWO_POL_BIT 7
`define LDPC_GEN_ONE_POL_BIT 6
`define LDPC_PERSIST_BIT     5
`define LDPC_C2_OVR_BIT      7
`define LDPC_T2_OVR_BIT      6
`define LDPC_C1_OVR_BIT      5
`define LDPC_T1_OVR_BIT      4
`define LDPC_INDEX_MASK      8'h3f

// ----------------------------------------------------------------------------
// Table bases and reset values
// ----------------------------------------------------------------------------
`define LDPC_T1_BASE         9'h090
`define LDPC_T2_BASE         9'h0d0
`define LDPC_FACTORY_VALUE   8'h00

`endif

// ==== hdl/ldpc_pkg.sv ====
// Types shared by the path control register bank
package ldpc_pkg;

  typedef enum logic [1:0] {
    LDPC_LOAD = 2'b01,
    LDPC_RUN  = 2'b10
  } ldpc_state_t;

  typedef logic [7:0] ldpc_byte_t;

  typedef struct packed {
    ldpc_state_t                 state;
    logic [2:0]                  load_idx;
    ldpc_byte_t [5:0]            ctrl;
    logic                        nv_we;
    logic [2:0]                  nv_idx;
    ldpc_byte_t                  nv_wdata;
    ldpc_byte_t                  rdata;
    logic                        rvalid;
    logic                        ready;
    logic [8:0]                  t1_addr;
    logic [8:0]                  t2_addr;
    ldpc_byte_t                  c1_code;
    ldpc_byte_t                  c2_code;
    logic                        g1_sink;
    logic                        g2_sink;
  } ldpc_regs_t;

endpackage : ldpc_pkg

// ==== hdl/ldpc_nv_if.sv ====
// Link between the register bank and its nonvolatile cell store
`timescale 1ns/1ps
`default_nettype none
interface ldpc_nv_if;
  logic       we;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bank  (output we, output idx, output wdata, input rdata);
  modport store (input we, input idx, input wdata, output rdata);
endinterface : ldpc_nv_if
`default_nettype wire

// ==== hdl/ldpc_nv_store.sv ====
// Nonvolatile cell store for control registers 0 to 5
`timescale 1ns/1ps
`default_nettype none
`include "ldpc_defs.svh"
module ldpc_nv_store
  import ldpc_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  factory_rst_n_in,
  ldpc_nv_if.store   nv
);

  ldpc_byte_t [5:0] cells;
  ldpc_byte_t [5:0] next_cells;

  // Cell update from the bank write port
  always_comb begin
    next_cells = cells;
    if (nv.we && (nv.idx <= `LDPC_LAST_IDX)) begin
      next_cells[nv.idx] = nv.wdata;
    end
  end

  // Cells hold across power cycles, cleared only by factory programming
  always_ff @(posedge clk_in or negedge factory_rst_n_in) begin
    if (!factory_rst_n_in) begin
      cells <= {`LDPC_NUM_CTRL{`LDPC_FACTORY_VALUE}};
    end else begin
      cells <= next_cells;
    end
  end

  // Indexed read of one cell
  assign nv.rdata = (nv.idx <= `LDPC_LAST_IDX) ? cells[nv.idx] : 8'h00;

endmodule : ldpc_nv_store
`default_nettype wire

// ==== hdl/ldpc_bank.sv ====
// Control register bank steering table addressing and converter inputs
`timescale 1ns/1ps
`default_nettype none
`include "ldpc_defs.svh"
module ldpc_bank
  import ldpc_pkg::*;
(
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       FACTORY_RST_N_IN,
  input  wire logic [7:0] ACC_ADDR_IN,
  input  wire logic [7:0] ACC_WDATA_IN,
  input  wire logic       ACC_WR_IN,
  input  wire logic       ACC_RD_IN,
  input  wire logic [7:0] CONV_RESULT_IN,
  input  wire logic [7:0] T1_ROW_DATA_IN,
  input  wire logic [7:0] T2_ROW_DATA_IN,
  output logic      [7:0] ACC_RDATA_OUT,
  output logic            ACC_RVALID_OUT,
  output logic            ACC_READY_OUT,
  output logic      [8:0] T1_ROW_ADDR_OUT,
  output logic      [8:0] T2_ROW_ADDR_OUT,
  output logic      [7:0] C1_CODE_OUT,
  output logic      [7:0] C2_CODE_OUT,
  output logic            GEN_ONE_SINK_OUT,
  output logic            GEN_TWO_SINK_OUT
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------

  // Base plus a six-bit row index
  function automatic logic [8:0] row_addr(input logic [8:0] base, input logic [5:0] idx);
    row_addr = base + {3'h0, idx};
  endfunction : row_addr

  // Map a register address to a control index, 3'h7 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - `LDPC_ADDR_CFG;
    if (addr >= `LDPC_ADDR_CFG && addr <= `LDPC_ADDR_PATH_SEL) begin
      reg_index = off[2:0];
    end else begin
      reg_index = 3'h7;
    end
  endfunction : reg_index

  // Stored width per register, reserved bits kept at zero
  function automatic logic [7:0] store_mask(input logic [2:0] idx);
    if (idx == 3'h1 || idx == 3'h2) begin
      store_mask = `LDPC_INDEX_MASK;
    end else begin
      store_mask = 8'hff;
    end
  endfunction : store_mask

  // Cell write decision: control 0 and 5 always persist, 1 to 4 on demand
  function automatic logic cell_write(input logic [2:0] idx, input logic persist);
    if (idx == 3'h0 || idx == 3'h5) begin
      cell_write = 1'b1;
    end else begin
      cell_write = persist;
    end
  endfunction : cell_write

  // Table row address from the written index or the converter result
  function automatic logic [8:0] table_addr(input logic       ovr,
                                            input logic [8:0] base,
                                            input logic [7:0] index,
                                            input logic [7:0] conv);
    if (ovr) begin
      table_addr = row_addr(base, index[5:0]);
    end else begin
      table_addr = row_addr(base, conv[7:2]);
    end
  endfunction : table_addr

  // Converter input from the direct code or the selected table row
  function automatic logic [7:0] pick_code(input logic sel, input logic [7:0] code, input logic [7:0] row);
    if (sel) begin
      pick_code = code;
    end else begin
      pick_code = row;
    end
  endfunction : pick_code

  // Read mux, unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input logic [2:0] idx, input ldpc_byte_t [5:0] ctrl);
    if (idx == 3'h7) begin
      reg_read = 8'h00;
    end else begin
      reg_read = ctrl[idx];
    end
  endfunction : reg_read

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  ldpc_regs_t r;
  ldpc_regs_t next_r;
  ldpc_nv_if  nv ();
  logic [2:0] acc_idx;
  logic       persist_now;
  logic       wr_take;
  ldpc_byte_t wr_value;

  // ----------------------------------------------------------------------------
  // Nonvolatile store
  // ----------------------------------------------------------------------------
  ldpc_nv_store u_nv_store (
    .clk_in           (CLK_IN),
    .factory_rst_n_in (FACTORY_RST_N_IN),
    .nv               (nv.store)
  );

  // Store port: write while running, walk indices while loading
  assign nv.we    = r.nv_we;
  assign nv.wdata = r.nv_wdata;
  assign nv.idx   = (r.state == LDPC_LOAD) ? r.load_idx : r.nv_idx;

  // ----------------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------------
  // Control index of the addressed register and the live persist select
  assign acc_idx     = reg_index(ACC_ADDR_IN);
  assign persist_now = r.ctrl[0][`LDPC_PERSIST_BIT];

  // Accepted writes and the stored form of the write byte
  assign wr_take  = ACC_WR_IN && (acc_idx != 3'h7);
  assign wr_value = ACC_WDATA_IN & store_mask(acc_idx);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.nv_we  = 1'b0;
    next_r.rvalid = 1'b0;
    case (r.state)
      LDPC_LOAD: begin
        // Restore control 0 to 5 from the cells after power-up
        next_r.ctrl[r.load_idx] = nv.rdata & store_mask(r.load_idx);
        next_r.load_idx         = r.load_idx + 3'h1;
        if (r.load_idx == `LDPC_LAST_IDX) begin
          next_r.state = LDPC_RUN;
        end
      end
      LDPC_RUN: begin
        // Register write, with copy to the cells when it persists
        if (wr_take) begin
          next_r.ctrl[acc_idx] = wr_value;
          next_r.nv_idx        = acc_idx;
          next_r.nv_wdata      = wr_value;
          next_r.nv_we         = cell_write(acc_idx, persist_now);
        end
        // Register read, unmapped reads as zero
        if (ACC_RD_IN) begin
          next_r.rvalid = 1'b1;
          next_r.rdata  = reg_read(acc_idx, r.ctrl);
        end
      end
      default: begin
        next_r.state    = LDPC_LOAD;
        next_r.load_idx = 3'h0;
      end
    endcase

    // Table addressing, written index or converter result
    next_r.t1_addr = table_addr(r.ctrl[5][`LDPC_T1_OVR_BIT], `LDPC_T1_BASE, r.ctrl[1], CONV_RESULT_IN);
    next_r.t2_addr = table_addr(r.ctrl[5][`LDPC_T2_OVR_BIT], `LDPC_T2_BASE, r.ctrl[2], CONV_RESULT_IN);

    // Converter inputs
    next_r.c1_code = pick_code(r.ctrl[5][`LDPC_C1_OVR_BIT], r.ctrl[3], T1_ROW_DATA_IN);
    next_r.c2_code = pick_code(r.ctrl[5][`LDPC_C2_OVR_BIT], r.ctrl[4], T2_ROW_DATA_IN);

    // Generator polarity
    next_r.g1_sink = r.ctrl[0][`LDPC_GEN_ONE_POL_BIT];
    next_r.g2_sink = r.ctrl[0][`LDPC_GEN_TWO_POL_BIT];

    // Ready once the power-up load walk is over
    next_r.ready = (next_r.state == LDPC_RUN);
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      r.state    <= LDPC_LOAD;
      r.load_idx <= 3'h0;
      r.ctrl     <= '0;
      r.nv_we    <= 1'b0;
      r.nv_idx   <= 3'h0;
      r.nv_wdata <= 8'h00;
      r.rdata    <= 8'h00;
      r.rvalid   <= 1'b0;
      r.ready    <= 1'b0;
      r.t1_addr  <= `LDPC_T1_BASE;
      r.t2_addr  <= `LDPC_T2_BASE;
      r.c1_code  <= 8'h00;
      r.c2_code  <= 8'h00;
      r.g1_sink  <= 1'b0;
      r.g2_sink  <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign ACC_RDATA_OUT    = r.rdata;
  assign ACC_RVALID_OUT   = r.rvalid;
  assign ACC_READY_OUT    = r.ready;
  assign T1_ROW_ADDR_OUT  = r.t1_addr;
  assign T2_ROW_ADDR_OUT  = r.t2_addr;
  assign C1_CODE_OUT      = r.c1_code;
  assign C2_CODE_OUT      = r.c2_code;
  assign GEN_ONE_SINK_OUT = r.g1_sink;
  assign GEN_TWO_SINK_OUT = r.g2_sink;

endmodule : ldpc_bank
`default_nettype wire

// ==== dv/ldpc_bank_assertions.sv ====
// Concurrent checks on the path control register bank ports
`timescale 1ns/1ps
`default_nettype none
module ldpc_bank_assertions (
  input wire logic       CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [7:0] ACC_ADDR_IN,
  input wire logic [7:0] ACC_WDATA_IN,
  input wire logic       ACC_WR_IN,
  input wire logic       ACC_RD_IN,
  input wire logic       ACC_READY_OUT,
  input wire logic [7:0] CONV_RESULT_IN,
  input wire logic [7:0] T1_ROW_DATA_IN,
  input wire logic [7:0] T2_ROW_DATA_IN,
  input wire logic [7:0] ACC_RDATA_OUT,
  input wire logic [8:0] T1_ROW_ADDR_OUT,
  input wire logic [8:0] T2_ROW_ADDR_OUT,
  input wire logic [7:0] C1_CODE_OUT,
  input wire logic [7:0] C2_CODE_OUT,
  input wire logic       GEN_ONE_SINK_OUT,
  input wire logic       GEN_TWO_SINK_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Accepted strobes only
  wire logic wr_ok = ACC_WR_IN && ACC_READY_OUT;
  wire logic rd_ok = ACC_RD_IN && ACC_READY_OUT;

  property p_gen1; wr_ok && ACC_ADDR_IN == 8'h80 |-> ##2 GEN_ONE_SINK_OUT == $past(ACC_WDATA_IN[6], 2); endproperty
  a_gen1: assert property (p_gen1) else $error("generator one polarity wrong");
  property p_gen2; wr_ok && ACC_ADDR_IN == 8'h80 |-> ##2 GEN_TWO_SINK_OUT == $past(ACC_WDATA_IN[7], 2); endproperty
  a_gen2: assert property (p_gen2) else $error("generator two polarity wrong");
  property p_idx1; rd_ok && ACC_ADDR_IN == 8'h81 |=> ACC_RDATA_OUT[7:6] == 2'h0; endproperty
  a_idx1: assert property (p_idx1) else $error("table one index high bits set");
  property p_idx2; rd_ok && ACC_ADDR_IN == 8'h82 |=> ACC_RDATA_OUT[7:6] == 2'h0; endproperty
  a_idx2: assert property (p_idx2) else $error("table two index high bits set");
  property p_rng1; T1_ROW_ADDR_OUT >= 9'h090 && T1_ROW_ADDR_OUT <= 9'h0cf; endproperty
  a_rng1: assert property (p_rng1) else $error("table one address out of range");
  property p_rng2; T2_ROW_ADDR_OUT >= 9'h0d0 && T2_ROW_ADDR_OUT <= 9'h10f; endproperty
  a_rng2: assert property (p_rng2) else $error("table two address out of range");
  property p_conv1;
    wr_ok && ACC_ADDR_IN == 8'h85 && !ACC_WDATA_IN[4] |-> ##2
      T1_ROW_ADDR_OUT == 9'h090 + {3'h0, $past(CONV_RESULT_IN[7:2])};
  endproperty
  a_conv1: assert property (p_conv1) else $error("table one not led by converter");
  property p_conv2;
    wr_ok && ACC_ADDR_IN == 8'h85 && !ACC_WDATA_IN[6] |-> ##2
      T2_ROW_ADDR_OUT == 9'h0d0 + {3'h0, $past(CONV_RESULT_IN[7:2])};
  endproperty
  a_conv2: assert property (p_conv2) else $error("table two not led by converter");
  property p_code1; wr_ok && ACC_ADDR_IN == 8'h85 && !ACC_WDATA_IN[5] |-> ##2 C1_CODE_OUT == $past(T1_ROW_DATA_IN); endproperty
  a_code1: assert property (p_code1) else $error("converter one not fed by row");
  property p_code2; wr_ok && ACC_ADDR_IN == 8'h85 && !ACC_WDATA_IN[7] |-> ##2 C2_CODE_OUT == $past(T2_ROW_DATA_IN); endproperty
  a_code2: assert property (p_code2) else $error("converter two not fed by row");

  // Main scenarios reached
  c_path: cover property (wr_ok && ACC_ADDR_IN == 8'h85);
  c_read: cover property (rd_ok && ACC_ADDR_IN == 8'h81);
  c_sink: cover property (GEN_TWO_SINK_OUT);
endmodule : ldpc_bank_assertions

bind ldpc_bank ldpc_bank_assertions ldpc_bank_assertions_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .ACC_ADDR_IN(ACC_ADDR_IN), .ACC_WDATA_IN(ACC_WDATA_IN), .ACC_WR_IN(ACC_WR_IN), .ACC_RD_IN(ACC_RD_IN),
  .ACC_READY_OUT(ACC_READY_OUT), .CONV_RESULT_IN(CONV_RESULT_IN), .T1_ROW_DATA_IN(T1_ROW_DATA_IN),
  .T2_ROW_DATA_IN(T2_ROW_DATA_IN), .ACC_RDATA_OUT(ACC_RDATA_OUT), .T1_ROW_ADDR_OUT(T1_ROW_ADDR_OUT),
  .T2_ROW_ADDR_OUT(T2_ROW_ADDR_OUT), .C1_CODE_OUT(C1_CODE_OUT), .C2_CODE_OUT(C2_CODE_OUT),
  .GEN_ONE_SINK_OUT(GEN_ONE_SINK_OUT), .GEN_TWO_SINK_OUT(GEN_TWO_SINK_OUT));
`default_nettype wire

// ==== dv/ldpc_host_model.sv ====
// Host side model driving the register access strobe port
`timescale 1ns/1ps
`default_nettype none
module ldpc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
  end
  // One write strobe; reserved index bits sent as zero
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = (a == 8'h81 || a == 8'h82) ? (d & 8'h3f) : d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a; // Released lines stop showing old value
    wdata_out = ~wdata_out;
  endtask : wr
  // One read strobe; answer taken while its one-cycle valid pulse stands
  task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    v = rvalid_in;
    d = rdata_in;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask : rd
endmodule : ldpc_host_model
`default_nettype wire

// ==== dv/test_ldpc_bank.sv ====
// Self-checking bench for the path control register bank
`timescale 1ns/1ps
`default_nettype none
module test_ldpc_bank;
  logic       clk, rst_n, frst_n, v, rdy, rv, we, re, g1, g2;
  logic [7:0] conv, t1d, t2d, d, i1, i2, c3, c4, ad, wd, rdat, c1, c2;
  logic [8:0] t1a, t2a;
  int         n_mismatch, total_checks, cyc;

  ldpc_bank ldpc_bank_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .FACTORY_RST_N_IN(frst_n), .ACC_ADDR_IN(ad),
    .ACC_WDATA_IN(wd), .ACC_WR_IN(we), .ACC_RD_IN(re), .CONV_RESULT_IN(conv), .T1_ROW_DATA_IN(t1d),
    .T2_ROW_DATA_IN(t2d), .ACC_RDATA_OUT(rdat), .ACC_RVALID_OUT(rv), .ACC_READY_OUT(rdy),
    .T1_ROW_ADDR_OUT(t1a), .T2_ROW_ADDR_OUT(t2a), .C1_CODE_OUT(c1), .C2_CODE_OUT(c2),
    .GEN_ONE_SINK_OUT(g1), .GEN_TWO_SINK_OUT(g2));
  ldpc_host_model ldpc_host_model_inst (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .addr_out(ad),
    .wdata_out(wd), .wr_out(we), .rd_out(re));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task do_reset;
    int k;
    @(negedge clk) rst_n = 1'b0;
    repeat (10) @(negedge clk);
    chk("ready in reset", {8'h0, rdy}, 9'h000);
    rst_n = 1'b1;
    k = 0;
    while (k < 50 && rdy !== 1'b1) begin
      @(negedge clk);
      k++;
    end
    chk("load cycles", k[8:0], 9'h006);
  endtask : do_reset
  task rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    ldpc_host_model_inst.rd(a, d, v);
    chk("rvalid", {8'h0, v}, 9'h001);
    chk(nm, {1'b0, d}, {1'b0, exp});
  endtask : rdchk
  // Expected row address from a base and an index
  function automatic logic [8:0] row(input logic [8:0] base, input logic [7:0] idx);
    return base + {3'h0, idx[5:0]};
  endfunction : row

  initial begin
    {rst_n, frst_n, conv, t1d, t2d} = 26'h0;
    void'($urandom(96));
    @(negedge clk) frst_n = 1'b1;
    do_reset();
    for (int a = 'h80; a <= 'h85; a++) rdchk("power-up", a[7:0], 8'h00);
    rdchk("unmapped", 8'h86, 8'h00);
    $display("test power-up done");
    for (int k = 0; k < 4; k++) begin
      ldpc_host_model_inst.wr(8'h80, {k[1:0], 6'h0});
      repeat (3) @(negedge clk);
      chk("gen one", {8'h0, g1}, {8'h0, k[0]});
      chk("gen two", {8'h0, g2}, {8'h0, k[1]});
    end
    $display("test polarity done");
    for (int k = 0; k < 6; k++) begin
      i1 = (k == 0) ? 8'h3f : (k == 1) ? 8'h00 : 8'($urandom);
      {i2, c3, c4} = 24'($urandom);
      ldpc_host_model_inst.wr(8'h81, i1);
      ldpc_host_model_inst.wr(8'h82, i2);
      ldpc_host_model_inst.wr(8'h83, c3);
      ldpc_host_model_inst.wr(8'h84, c4);
      ldpc_host_model_inst.wr(8'h85, 8'hf0);
      rdchk("table one index", 8'h81, i1 & 8'h3f);
      rdchk("table two index", 8'h82, i2 & 8'h3f);
      rdchk("converter one code", 8'h83, c3);
      rdchk("converter two code", 8'h84, c4);
      chk("t1 addr", t1a, row(9'h090, i1));
      chk("t2 addr", t2a, row(9'h0d0, i2));
      chk("c1 code", {1'b0, c1}, {1'b0, c3});
      chk("c2 code", {1'b0, c2}, {1'b0, c4});
      ldpc_host_model_inst.wr(8'h85, 8'h00);
      {conv, t1d, t2d} = 24'($urandom);
      repeat (3) @(negedge clk);
      chk("t1 conv addr", t1a, row(9'h090, conv >> 2));
      chk("t2 conv addr", t2a, row(9'h0d0, conv >> 2));
      chk("c1 row", {1'b0, c1}, {1'b0, t1d});
      chk("c2 row", {1'b0, c2}, {1'b0, t2d});
    end
    $display("test path select done");
    ldpc_host_model_inst.wr(8'h80, 8'h20);
    ldpc_host_model_inst.wr(8'h81, 8'h2a);
    ldpc_host_model_inst.wr(8'h80, 8'h00);
    ldpc_host_model_inst.wr(8'h82, 8'h15);
    repeat (4) @(negedge clk);
    do_reset();
    rdchk("persisted index", 8'h81, 8'h2a);
    rdchk("volatile index", 8'h82, 8'h00);
    rdchk("reloaded config", 8'h80, 8'h00);
    $display("test persistence done");
    report_and_stop();
  end
endmodule : test_ldpc_bank
`default_nettype wire
